// ### logic/mac_pkg.sv
// Package for the monitor alert compare logic: offsets, fields, resets.
// Assumes a simple internal register port from the serial interface core.
//
// Behaviour
// - Shunt high enable alerts on shunt above threshold
// - Shunt low alerts below; blocked by high
// - Supply high alerts; blocked by shunt enables
// - Supply low alerts; blocked by higher enables
// - Power high alerts; blocked by other enables
// - Ready-on-pin routes sample done to alert
// - One compare source plus optional ready
// - Latched compare flag clears on mask read
// - Transparent flag clears after non-alert conversion
// - Sample done set after full cycle completes
// - Config write clears done, except power-down
// - Mask register read clears sample done
// - Overflow flag set on arithmetic overflow
// - Sense select sets alert output polarity
// - Transparent mode returns alert idle
// - Latched mode holds alert until read
// - Threshold compared against selected result
// - Threshold at 7h, read-write, resets zero
package mac_pkg;
   localparam logic [3:0]  REG_MASK_EN   = 4'h6;
   localparam logic [3:0]  REG_THRESHOLD = 4'h7;
   localparam int          BIT_SHUNT_HI  = 15;
   localparam int          BIT_SHUNT_LO  = 14;
   localparam int          BIT_SUPPLY_HI = 13;
   localparam int          BIT_SUPPLY_LO = 12;
   localparam int          BIT_POWER_HI  = 11;
   localparam int          BIT_READY_PIN = 10;
   localparam int          BIT_STORE_ERR = 5;
   localparam int          BIT_CMP_SRC   = 4;
   localparam int          BIT_DONE      = 3;
   localparam int          BIT_OVF       = 2;
   localparam int          BIT_SENSE     = 1;
   localparam int          BIT_LATCH     = 0;
   localparam logic [15:0] THRESH_RST    = 16'h0000;
   localparam logic [15:0] WR_MASK       = 16'hFC03;

   typedef struct packed {
      logic        valid;
      logic [15:0] shunt;
      logic [15:0] supply;
      logic [15:0] power;
      logic        overflow;
   } mac_result_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [3:0]  addr;
      logic [15:0] wdata;
   } mac_reg_req_t;
endpackage

// ### logic/mac_cmp_unit.sv
// Threshold comparator: picks the enabled source and flags a violation.
// Assumes one compare enable at most, as the control write guards.
`timescale 1ns/1ns
module mac_cmp_unit
(
   input  wire logic [4:0]  enables_i,
   input  wire logic [15:0] shunt_i,
   input  wire logic [15:0] supply_i,
   input  wire logic [15:0] power_i,
   input  wire logic [15:0] threshold_i,
   output logic             violation_o
);
   always_comb
   begin
      violation_o = 1'b0;
      if (enables_i[4])
         violation_o = $signed(shunt_i) > $signed(threshold_i);
      else if (enables_i[3])
         violation_o = $signed(shunt_i) < $signed(threshold_i);
      else if (enables_i[2])
         violation_o = supply_i > threshold_i;
      else if (enables_i[1])
         violation_o = supply_i < threshold_i;
      else if (enables_i[0])
         violation_o = power_i > threshold_i;
   end
endmodule

// ### logic/mac_alert_top.sv
// Alert control top: mask/enable and threshold registers, flags, pin.
// Assumes results arrive as one-cycle valid after a complete cycle.
`timescale 1ns/1ns
module mac_alert_top
(
   input  wire logic                 sys_clk_i,
   input  wire logic                 sys_rst_i,
   input  wire mac_pkg::mac_reg_req_t reg_req_i,
   input  wire mac_pkg::mac_result_t  result_i,
   input  wire logic                 cfg_wr_i,
   input  wire logic                 cfg_pwrdn_i,
   input  wire logic                 store_err_i,
   output logic [15:0]               reg_rdata_o,
   output logic                      alert_o,
   output logic                      alert_oe_o
);
   logic [15:0] threshold_r;
   logic [4:0]  enables_r;
   logic        ready_pin_r;
   logic        sense_r;
   logic        latch_r;
   logic        cmp_src_r;
   logic        done_r;
   logic        ovf_r;
   logic        store_err_r;
   logic        violation;
   logic        mask_rd;
   logic        mask_wr;
   logic        thr_wr;
   logic [15:0] mask_word;
   logic [4:0]  en_nxt;
   logic [4:0]  en_raw;
   logic        alert_act;

   assign mask_rd = reg_req_i.rd && (reg_req_i.addr == mac_pkg::REG_MASK_EN);
   assign mask_wr = reg_req_i.wr && (reg_req_i.addr == mac_pkg::REG_MASK_EN);
   assign thr_wr  = reg_req_i.wr && (reg_req_i.addr == mac_pkg::REG_THRESHOLD);
   assign en_raw  = reg_req_i.wdata[mac_pkg::BIT_SHUNT_HI:mac_pkg::BIT_POWER_HI];

   mac_cmp_unit u_cmp
   (
      .enables_i   (enables_r),
      .shunt_i     (result_i.shunt),
      .supply_i    (result_i.supply),
      .power_i     (result_i.power),
      .threshold_i (threshold_r),
      .violation_o (violation)
   );

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         threshold_r <= mac_pkg::THRESH_RST;
      else if (thr_wr)
         threshold_r <= reg_req_i.wdata;
   end

   always_comb
   begin
      en_nxt = en_raw;
      for (int i = 3; i >= 0; i--)
      begin
         if ((en_raw >> (i + 1)) != 5'h00)
            en_nxt[i] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         enables_r   <= 5'h00;
         ready_pin_r <= 1'b0;
         sense_r     <= 1'b0;
         latch_r     <= 1'b0;
      end
      else if (mask_wr)
      begin
         enables_r   <= en_nxt;
         ready_pin_r <= reg_req_i.wdata[mac_pkg::BIT_READY_PIN];
         sense_r     <= reg_req_i.wdata[mac_pkg::BIT_SENSE];
         latch_r     <= reg_req_i.wdata[mac_pkg::BIT_LATCH];
      end
   end

   // Compare flag; a new violation beats a read clear
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         cmp_src_r <= 1'b0;
      else if (result_i.valid && violation)
         cmp_src_r <= 1'b1;
      else if (!latch_r && result_i.valid)
         cmp_src_r <= 1'b0;
      else if (latch_r && mask_rd)
         cmp_src_r <= 1'b0;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         done_r <= 1'b0;
      else if (result_i.valid)
         done_r <= 1'b1;
      else if (cfg_wr_i && !cfg_pwrdn_i)
         done_r <= 1'b0;
      else if (mask_rd)
         done_r <= 1'b0;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         ovf_r <= 1'b0;
      else if (result_i.valid)
         ovf_r <= result_i.overflow;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         store_err_r <= 1'b0;
      else
         store_err_r <= store_err_i;
   end

   always_comb
   begin
      mask_word = 16'h0000;
      mask_word[mac_pkg::BIT_SHUNT_HI:mac_pkg::BIT_POWER_HI] = enables_r;
      mask_word[mac_pkg::BIT_READY_PIN] = ready_pin_r;
      mask_word[mac_pkg::BIT_STORE_ERR] = store_err_r;
      mask_word[mac_pkg::BIT_CMP_SRC]   = cmp_src_r;
      mask_word[mac_pkg::BIT_DONE]      = done_r;
      mask_word[mac_pkg::BIT_OVF]       = ovf_r;
      mask_word[mac_pkg::BIT_SENSE]     = sense_r;
      mask_word[mac_pkg::BIT_LATCH]     = latch_r;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         reg_rdata_o <= 16'h0000;
      else if (reg_req_i.rd)
         unique case (reg_req_i.addr)
            mac_pkg::REG_MASK_EN:   reg_rdata_o <= mask_word;
            mac_pkg::REG_THRESHOLD: reg_rdata_o <= threshold_r;
            default:                reg_rdata_o <= 16'h0000;
         endcase
   end

   // live or held flag drives alert
   assign alert_act = cmp_src_r || (ready_pin_r && done_r);

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         alert_o    <= 1'b1;
         alert_oe_o <= 1'b0;
      end
      else if (sense_r)
      begin
         alert_o    <= alert_act;
         alert_oe_o <= 1'b1;
      end
      else
      begin
         alert_o    <= 1'b0;
         alert_oe_o <= alert_act;
      end
   end

   one_enable_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $onehot0(enables_r)) else $error("two compare enables set");
   latch_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      latch_r && cmp_src_r && !mask_rd && !mask_wr |=> cmp_src_r)
      else $error("latched flag lost");
   transp_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !latch_r && result_i.valid && !violation |=> !cmp_src_r)
      else $error("flag not cleared");
   done_set_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      result_i.valid |=> done_r) else $error("done not set");
   done_rd_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_rd && !result_i.valid |=> !done_r) else $error("done not cleared");
   pwrdn_keep_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      cfg_wr_i && cfg_pwrdn_i && !mask_rd && done_r |=> done_r)
      else $error("done lost on power-down");
   sense_hi_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      sense_r && cmp_src_r && !mask_wr |=> alert_o && alert_oe_o)
      else $error("alert not high");
   viol_flag_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      result_i.valid && violation |=> cmp_src_r ##1
      (alert_oe_o && (alert_o == $past(sense_r))))
      else $error("violation missed");

   thr_write_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      thr_wr
      |=> threshold_r == $past(reg_req_i.wdata))
      else $error("threshold write lost");
   thr_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !thr_wr
      |=> $stable(threshold_r))
      else $error("threshold changed unwritten");
   shunt_lo_block_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_wr && reg_req_i.wdata[mac_pkg::BIT_SHUNT_HI]
      |=> !enables_r[3])
      else $error("shunt low enable not blocked");
   supply_hi_block_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_wr && (reg_req_i.wdata[mac_pkg::BIT_SHUNT_HI:mac_pkg::BIT_SHUNT_LO] != 2'b00)
      |=> !enables_r[2])
      else $error("supply high enable not blocked");
   supply_lo_block_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_wr && (reg_req_i.wdata[mac_pkg::BIT_SHUNT_HI:mac_pkg::BIT_SUPPLY_HI] != 3'b000)
      |=> !enables_r[1])
      else $error("supply low enable not blocked");
   power_block_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_wr && (reg_req_i.wdata[mac_pkg::BIT_SHUNT_HI:mac_pkg::BIT_SUPPLY_LO] != 4'h0)
      |=> !enables_r[0])
      else $error("power enable not blocked");
   top_enable_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_wr
      |=> enables_r[4] == $past(reg_req_i.wdata[mac_pkg::BIT_SHUNT_HI]))
      else $error("shunt high enable lost");
   ready_copy_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_wr
      |=> ready_pin_r == $past(reg_req_i.wdata[mac_pkg::BIT_READY_PIN]))
      else $error("ready enable not written");
   ctrl_copy_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_wr
      |=> {sense_r, latch_r} == $past(reg_req_i.wdata[mac_pkg::BIT_SENSE:mac_pkg::BIT_LATCH]))
      else $error("sense or latch not written");
   ctrl_keep_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !mask_wr
      |=> $stable({enables_r, ready_pin_r, sense_r, latch_r}))
      else $error("control field changed unwritten");
   resv_zero_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_rd
      |=> reg_rdata_o[mac_pkg::BIT_READY_PIN-1:mac_pkg::BIT_STORE_ERR+1] == 4'h0)
      else $error("reserved bits not zero");
   store_flag_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_rd
      |=> reg_rdata_o[mac_pkg::BIT_STORE_ERR] == $past(store_err_r))
      else $error("storage fault not reported");
   ready_alert_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      ready_pin_r && done_r
      |=> alert_oe_o && (alert_o == $past(sense_r)))
      else $error("ready not on pin");
   drain_low_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !sense_r
      |=> !alert_o)
      else $error("open-drain pin driven high");
   drive_on_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      sense_r
      |=> alert_oe_o)
      else $error("active-high pin not driven");
   transp_idle_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !latch_r && result_i.valid && !violation && !ready_pin_r && !mask_wr
      |=> !cmp_src_r ##1 !(alert_oe_o && (alert_o == $past(sense_r))))
      else $error("transparent pin not idle");
   latch_pin_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      latch_r && cmp_src_r
      |=> alert_oe_o && (alert_o == $past(sense_r)))
      else $error("latched pin not active");
   latch_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      latch_r && mask_rd && !(result_i.valid && violation)
      |=> !cmp_src_r)
      else $error("latched flag not cleared");
   no_src_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (enables_r == 5'h00) && !cmp_src_r
      |=> !cmp_src_r)
      else $error("flag without compare source");
   cfg_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      cfg_wr_i && !cfg_pwrdn_i && !result_i.valid
      |=> !done_r)
      else $error("done not cleared by config");
   done_only_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !done_r && !result_i.valid
      |=> !done_r)
      else $error("done set without result");
   ovf_track_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      result_i.valid
      |=> ovf_r == $past(result_i.overflow))
      else $error("overflow not taken");
   ovf_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      !result_i.valid
      |=> $stable(ovf_r))
      else $error("overflow changed without result");
   rd_thr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      reg_req_i.rd && (reg_req_i.addr == mac_pkg::REG_THRESHOLD)
      |=> reg_rdata_o == $past(threshold_r))
      else $error("threshold read wrong");
   done_read_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      mask_rd
      |=> reg_rdata_o[mac_pkg::BIT_DONE] == $past(done_r))
      else $error("done not shown on read");
   cov_latch_c: cover property (@(posedge sys_clk_i) latch_r && cmp_src_r ##1 mask_rd);
   cov_ready_c: cover property (@(posedge sys_clk_i) ready_pin_r && done_r);
   cov_sense_c: cover property (@(posedge sys_clk_i) sense_r && alert_o);
   cov_drain_c: cover property (@(posedge sys_clk_i) !sense_r && alert_oe_o);
   cov_transp_c: cover property (@(posedge sys_clk_i) !latch_r && cmp_src_r ##1 !cmp_src_r);
endmodule

// ### tb/mac_host_model.sv
// Host model: register reads and writes on the internal register port.
// Assumes the device takes a request on the rising edge it sees it.
`timescale 1ns/1ns
module mac_host_model
(
   input  wire logic             sys_clk_i,
   input  wire logic [15:0]      rdata_i,
   output mac_pkg::mac_reg_req_t reg_req_o
);
   initial reg_req_o = '0;

   task automatic xfer(input logic rd, input logic [3:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      @(negedge sys_clk_i);
      reg_req_o = '{rd: rd, wr: !rd, addr: a, wdata: d};
      @(negedge sys_clk_i);
      // Idle bus shows inverted values so stale data is never mistaken
      reg_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      @(negedge sys_clk_i);
      q = rdata_i;
   endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the alert compare top.
// Assumes the host model drives the register port; inputs change at negedge.
`timescale 1ns/1ns
module testbench;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   mac_pkg::mac_result_t  res = '0;
   logic                  cfg_wr = 1'b0;
   logic                  cfg_pwrdn = 1'b0;
   logic                  store_err = 1'b0;
   mac_pkg::mac_reg_req_t req;
   logic [15:0]           rdata;
   logic                  alert;
   logic                  oe;
   logic [15:0]           q;
   logic [15:0]           v;
   logic [15:0]           w;
   int                    bad_count = 0;
   int                    check_count = 0;

   always #2 clk = ~clk;

   mac_alert_top u_mac_alert_top (.sys_clk_i(clk), .sys_rst_i(rst), .reg_req_i(req),
      .result_i(res), .cfg_wr_i(cfg_wr), .cfg_pwrdn_i(cfg_pwrdn), .store_err_i(store_err),
      .reg_rdata_o(rdata), .alert_o(alert), .alert_oe_o(oe));
   mac_host_model u_mac_host_model (.sys_clk_i(clk), .rdata_i(rdata), .reg_req_o(req));

   task automatic chk_word(input logic [15:0] a, input logic [15:0] e);
      check_count++;
      if (a !== e)
      begin
         bad_count++;
         $display("MISMATCH t=%0t act=%h exp=%h", $time, a, e);
      end
   endtask

   // Pin pair checked as {oe, alert}
   task automatic chk_pin(input logic [1:0] e);
      check_count++;
      if ({oe, alert} !== e)
      begin
         bad_count++;
         $display("MISMATCH t=%0t act=%h exp=%h", $time, {oe, alert}, e);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      u_mac_host_model.xfer(1'b0, a, d, q);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      u_mac_host_model.xfer(1'b1, a, 16'h0000, q);
      chk_word(q, e);
   endtask

   // Alert pin settles two edges after the valid edge
   task automatic send(input logic [15:0] sh, input logic [15:0] su, input logic [15:0] pw,
                       input logic ov);
      @(negedge clk);
      res = '{valid: 1'b1, shunt: sh, supply: su, power: pw, overflow: ov};
      @(negedge clk);
      res.valid = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic cfg(input logic pd);
      @(negedge clk);
      cfg_wr = 1'b1;
      cfg_pwrdn = pd;
      @(negedge clk);
      cfg_wr = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic t_reset;
      chk_pin(2'b01);
      rd_chk(mac_pkg::REG_THRESHOLD, 16'h0000);
      rd_chk(mac_pkg::REG_MASK_EN, 16'h0000);
      wr(mac_pkg::REG_THRESHOLD, 16'hA5C3);
      rd_chk(mac_pkg::REG_THRESHOLD, 16'hA5C3);
      rd_chk(4'h5, 16'h0000);
      $display("t_reset done");
   endtask

   task automatic t_prio;
      store_err = 1'b1;
      wr(mac_pkg::REG_MASK_EN, 16'hF800);
      rd_chk(mac_pkg::REG_MASK_EN, 16'h8020);
      wr(mac_pkg::REG_MASK_EN, 16'h3C00);
      rd_chk(mac_pkg::REG_MASK_EN, 16'h2420);
      wr(mac_pkg::REG_MASK_EN, 16'h1800);
      rd_chk(mac_pkg::REG_MASK_EN, 16'h1020);
      wr(mac_pkg::REG_MASK_EN, 16'h03FF);
      rd_chk(mac_pkg::REG_MASK_EN, 16'h0023);
      store_err = 1'b0;
      $display("t_prio done");
   endtask

   // Unselected sources carry values that would trip the wrong compare
   task automatic t_compare;
      logic [15:0] en [5];
      en = '{16'h8002, 16'h4002, 16'h2002, 16'h1002, 16'h0802};
      wr(mac_pkg::REG_THRESHOLD, 16'h0100);
      for (int i = 0; i < 5; i++)
      begin
         v = (i % 2 == 1) ? 16'h0080 : 16'h0200;
         w = ~v & 16'h0280;
         wr(mac_pkg::REG_MASK_EN, en[i]);
         send(i < 2 ? v : w, i / 2 == 1 ? v : w, i == 4 ? v : w, 1'b0);
         chk_pin(2'b11);
         send(i < 2 ? w : v, i / 2 == 1 ? w : v, i == 4 ? w : v, 1'b0);
         chk_pin(2'b10);
      end
      $display("t_compare done");
   endtask

   task automatic t_latch;
      wr(mac_pkg::REG_THRESHOLD, 16'hFFF0);
      wr(mac_pkg::REG_MASK_EN, 16'h8000);
      send(16'h0005, 16'h0000, 16'h0000, 1'b0);
      chk_pin(2'b10);
      rd_chk(mac_pkg::REG_MASK_EN, 16'h8018);
      send(16'hFF00, 16'h0000, 16'h0000, 1'b0);
      chk_pin(2'b00);
      rd_chk(mac_pkg::REG_MASK_EN, 16'h8008);
      wr(mac_pkg::REG_MASK_EN, 16'h8003);
      send(16'h0005, 16'h0000, 16'h0000, 1'b0);
      send(16'hFF00, 16'h0000, 16'h0000, 1'b0);
      chk_pin(2'b11);
      rd_chk(mac_pkg::REG_MASK_EN, 16'h801B);
      chk_pin(2'b10);
      rd_chk(mac_pkg::REG_MASK_EN, 16'h8003);
      $display("t_latch done");
   endtask

   task automatic t_ready;
      wr(mac_pkg::REG_MASK_EN, 16'h0402);
      send(16'h0000, 16'h0000, 16'h0000, 1'b1);
      chk_pin(2'b11);
      cfg(1'b1);
      chk_pin(2'b11);
      cfg(1'b0);
      chk_pin(2'b10);
      rd_chk(mac_pkg::REG_MASK_EN, 16'h0406);
      $display("t_ready done");
   endtask

   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      t_reset;
      t_prio;
      t_compare;
      t_latch;
      t_ready;
      end_sim;
   end

   // Run needs about 160 cycles; generous margin
   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count++;
      end_sim;
   end
endmodule
